/* File: dv/line_partner.sv */
/*
  Far side of the query handler: the coil/register map and the reply line.
  Assumes the bench toggles slow to make the line accept bytes prompt or late.
*/
`timescale 1ns/100ps
module line_partner (
  input wire logic clk_sys,
  input wire logic slow,
  input wire logic [15:0] item_addr,
  input wire logic item_coil,
  output logic [7:0] item_code,
  output logic tx_ready
);
  // The high page does not exist, and one item rejects by kind: a coil is locked, a register is out of range.
  assign item_code = item_addr >= 16'hf000 ? 8'h02 :
                     item_addr == 16'hbeef ? (item_coil ? 8'h22 : 8'h21) : 8'h00;
  always @(posedge clk_sys) begin
    tx_ready <= slow ? ($urandom_range(3, 0) == 0) : 1'b1;
  end
endmodule

/* File: dv/tb_modbus_multi_write.sv */
/*
  Self-checking bench for the multiple-write query handler.
  Assumes the handler takes whole frames and answers through a stalling line.
*/
`timescale 1ns/100ps
module tb_modbus_multi_write;
  typedef logic [7:0] b_t;
  logic clk_sys, slow = 1'b0, rst_n = 1'b0, rx_valid = 1'b0, rx_end = 1'b0;
  logic tx_ready, item_coil, item_wr, tx_valid, busy;
  logic [7:0] own_addr = 8'h05, rx_data = 8'h00, item_code, tx_data, f, n;
  logic [15:0] item_addr, item_data;
  logic [32:0] wr[$], ewr[$];
  b_t got[$], exp[$], fr[$];
  int error_cnt = 0, n_compared = 0;
  logic [47:0] xt[8] = '{48'h10_1000_03_05_03, 48'h0f_1000_09_01_03, 48'h03_1000_01_00_01,
    48'h10_beec_04_08_21, 48'h0f_beec_08_02_22, 48'h10_f000_01_02_02, 48'h10_1000_00_00_03,
    48'h10_1000_09_12_03};

  modbus_multi_write i_modbus_multi_write (.clk_sys(clk_sys), .rst_n(rst_n), .own_addr(own_addr),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_end(rx_end), .item_code(item_code), .tx_ready(tx_ready),
    .item_addr(item_addr), .item_data(item_data), .item_coil(item_coil), .item_wr(item_wr),
    .tx_data(tx_data), .tx_valid(tx_valid), .busy(busy));
  line_partner i_line_partner (.clk_sys(clk_sys), .slow(slow), .item_addr(item_addr),
    .item_coil(item_coil), .item_code(item_code), .tx_ready(tx_ready));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
    if (item_wr) wr.push_back({item_coil, item_addr, item_data});
  end

  task automatic check(logic [32:0] seen, logic [32:0] want);
    n_compared++;
    if (seen !== want) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, want);
    end
  endtask

  task automatic results();
    if (error_cnt == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // The CRC goes out low byte first, so a whole good frame leaves no residue.
  function automatic void seal(ref b_t q[$]);
    logic [15:0] c = 16'hffff;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
  endfunction

  task automatic mk(b_t a, b_t fn, logic [15:0] s, b_t cnt, b_t bc);
    fr = {a, fn, s[15:8], s[7:0], 8'h00, cnt, bc};
    repeat (bc) fr.push_back(8'($urandom));
    exp = fr[0:5];
    seal(exp);
    ewr = {};
    for (int i = 0; i < cnt; i++)
      ewr.push_back(fn == 8'h10 ? {1'b0, s + 16'(i) + 16'h1, fr[7+2*i], fr[8+2*i]}
                                : {1'b1, s + 16'(i) + 16'h1, 15'h0, fr[7+i/8][i%8]});
  endtask

  task automatic exc(b_t fn, b_t code);
    exp = {fr[0], fn | 8'h80, code};
    seal(exp);
    ewr = {};
  endtask

  task automatic run(bit bad);
    b_t q[$];
    q = fr;
    seal(q);
    if (bad) q[q.size()-1] ^= 8'h01;
    got = {};
    wr = {};
    foreach (q[i]) begin
      @(posedge clk_sys);
      rx_valid <= 1'b1;
      rx_data <= q[i];
    end
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    rx_end <= 1'b1;
    @(posedge clk_sys);
    rx_end <= 1'b0;
    repeat (2) @(posedge clk_sys);
    for (int k = 0; k < 5000 && busy !== 1'b0; k++) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
    check(33'(busy), 33'h0);
    check(33'(got.size()), 33'(exp.size()));
    foreach (exp[i]) check(33'(got[i]), 33'(exp[i]));
    check(33'(wr.size()), 33'(ewr.size()));
    foreach (ewr[i]) check(wr[i], ewr[i]);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    void'($urandom(32'hcc60));
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    for (int it = 0; it < 12; it++) begin
      f = it[0] ? 8'h10 : 8'h0f;
      n = it < 2 ? (it[0] ? 8'h08 : 8'h80) : 8'(it[0] ? $urandom_range(8, 1) : $urandom_range(128, 1));
      slow <= it[1];
      mk(own_addr, f, 16'($urandom_range(32'h7fff, 0)), n, 8'(f == 8'h10 ? 2 * n : (n + 15) / 16 * 2));
      run(1'b0);
    end
    foreach (xt[i]) begin
      mk(own_addr, xt[i][47:40], xt[i][39:24], xt[i][23:16], xt[i][15:8]);
      exc(xt[i][47:40], xt[i][7:0]);
      run(1'b0);
    end
    mk(8'h00, 8'h10, 16'h0200, 8'h02, 8'h04);
    exp = {};
    run(1'b0);
    mk(8'h00, 8'h10, 16'h0200, 8'h02, 8'h03);
    exp = {};
    ewr = {};
    run(1'b0);
    mk(own_addr + 8'h01, 8'h10, 16'h0200, 8'h01, 8'h02);
    exp = {};
    ewr = {};
    run(1'b0);
    mk(own_addr, 8'h10, 16'h0300, 8'h01, 8'h02);
    exp = {};
    ewr = {};
    run(1'b1);
    mk(own_addr, 8'h10, 16'h0300, 8'h01, 8'h02);
    fr.push_back(8'h00);
    exc(8'h10, 8'h03);
    run(1'b0);
    fr = {own_addr};
    exp = {};
    ewr = {};
    run(1'b0);
    results();
  end

  initial begin
    #500000;
    error_cnt++;
    results();
  end
endmodule

/* File: logic/crc16.sv */
/*
  Byte-serial CRC-16 with the reflected Modbus polynomial.
  Assumes clear and en are never high together; clear wins if they are.
*/
`timescale 1ns/100ps
module crc16 (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic en,
  input wire logic [7:0] data,
  output logic [15:0] crc
);
  logic [15:0] crc_reg;
  logic [15:0] crc_next;

  always_comb begin
    crc_next = crc_reg;
    if (clear) begin
      crc_next = mb_pkg::CRC_INIT;
    end else if (en) begin
      crc_next = crc_reg ^ {8'h00, data};
      for (int i = 0; i < 8; i++) begin
        crc_next = crc_next[0] ? ((crc_next >> 1) ^ mb_pkg::CRC_POLY) : (crc_next >> 1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      crc_reg <= mb_pkg::CRC_INIT;
    end else begin
      crc_reg <= crc_next;
    end
  end

  assign crc = crc_reg;
endmodule

/* File: logic/frame_tx.sv */
/*
  Response serialiser: fetches len bytes by index, then appends the CRC.
  Assumes byte_in answers byte_idx combinationally and stays stable while busy.
*/
`timescale 1ns/100ps
module frame_tx (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [3:0] len,
  input wire logic [7:0] byte_in,
  output logic [3:0] byte_idx,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic done
);
  mb_pkg::tx_state_e state_reg, state_next;
  logic [3:0] pos_reg, pos_next;
  logic [7:0] data_reg, data_next;
  logic valid_reg, valid_next;
  logic done_reg, done_next;
  logic take;
  logic load_data;
  logic [15:0] crc;

  // ---------------------------------------------------------------------------
  // Sequencing
  // ---------------------------------------------------------------------------
  assign take = !valid_reg || tx_ready;
  assign load_data = (state_reg == mb_pkg::TX_RUN) && take && (pos_reg < len);

  always_comb begin
    state_next = state_reg;
    pos_next = pos_reg;
    data_next = data_reg;
    valid_next = valid_reg;
    done_next = 1'b0;
    case (state_reg)
      mb_pkg::TX_IDLE: begin
        if (start) begin
          state_next = mb_pkg::TX_RUN;
          pos_next = '0;
        end
      end
      mb_pkg::TX_RUN: begin
        if (take) begin
          pos_next = pos_reg + 4'h1;
          valid_next = 1'b1;
          // The CRC goes out low byte first, which is crc[7:0], then crc[15:8].
          if (pos_reg < len) begin
            data_next = byte_in;
          end else if (pos_reg == len) begin
            data_next = crc[7:0];
          end else if (pos_reg == len + 4'h1) begin
            data_next = crc[15:8];
          end else begin
            valid_next = 1'b0;
            pos_next = pos_reg;
            done_next = 1'b1;
            state_next = mb_pkg::TX_IDLE;
          end
        end
      end
      default: state_next = mb_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= mb_pkg::TX_IDLE;
      pos_reg <= '0;
      data_reg <= '0;
      valid_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pos_reg <= pos_next;
      data_reg <= data_next;
      valid_reg <= valid_next;
      done_reg <= done_next;
    end
  end

  crc16 u_crc (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clear(start),
    .en(load_data),
    .data(byte_in),
    .crc(crc)
  );

  assign byte_idx = pos_reg;
  assign tx_data = data_reg;
  assign tx_valid = valid_reg;
  assign done = done_reg;

  a_crc_low_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_reg == mb_pkg::TX_RUN && take && pos_reg == len) |=> tx_valid && tx_data == $past(crc[7:0]))
    else $error("CRC low byte not sent right after the data bytes");
endmodule

/* File: logic/mb_pkg.sv */
/*
  Constants, field positions and state encodings shared by the multiple-write
  query handler, its CRC engine and its response serialiser.
  Assumes a byte-wide receive path that has already removed line framing.
*/
package mb_pkg;
  // ---------------------------------------------------------------------------
  // Function and exception codes
  // ---------------------------------------------------------------------------
  localparam logic [7:0] FN_COILS = 8'h0f;
  localparam logic [7:0] FN_REGS = 8'h10;
  localparam logic [7:0] FN_EXC = 8'h80;
  localparam logic [7:0] ADDR_BCAST = 8'h00;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_FORMAT = 8'h03;
  localparam logic [7:0] EXC_RANGE = 8'h21;
  localparam logic [7:0] EXC_LOCKED = 8'h22;

  // ---------------------------------------------------------------------------
  // Query layout and limits
  // ---------------------------------------------------------------------------
  localparam logic [7:0] POS_ADDR = 8'h00;
  localparam logic [7:0] POS_FN = 8'h01;
  localparam logic [7:0] POS_ST_HI = 8'h02;
  localparam logic [7:0] POS_ST_LO = 8'h03;
  localparam logic [7:0] POS_CNT_HI = 8'h04;
  localparam logic [7:0] POS_CNT_LO = 8'h05;
  localparam logic [7:0] POS_BC = 8'h06;
  localparam logic [7:0] HDR_LEN = 8'h07;
  localparam logic [7:0] CRC_LEN = 8'h02;
  localparam logic [7:0] MIN_LEN = 8'h04;
  localparam logic [7:0] POS_MAX = 8'hff;
  localparam int BUF_BYTES = 16;
  localparam logic [7:0] BUF_LEN = 8'h10;
  localparam logic [15:0] MAX_REGS = 16'h0008;
  localparam logic [15:0] MAX_COILS = 16'h0080;
  localparam logic [15:0] ADDR_STEP = 16'h0001;
  localparam logic [15:0] COIL_ROUND = 16'h0007;
  localparam int COIL_SHIFT = 3;

  // ---------------------------------------------------------------------------
  // Response layout and CRC
  // ---------------------------------------------------------------------------
  localparam logic [3:0] RI_ADDR = 4'h0;
  localparam logic [3:0] RI_FN = 4'h1;
  localparam logic [3:0] RI_ST_HI = 4'h2;
  localparam logic [3:0] RI_ST_LO = 4'h3;
  localparam logic [3:0] RI_CNT_HI = 4'h4;
  localparam logic [3:0] RI_CNT_LO = 4'h5;
  localparam logic [3:0] RSP_LEN_OK = 4'h6;
  localparam logic [3:0] RSP_LEN_EXC = 4'h3;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_GOOD = 16'h0000;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01, S_EVAL = 6'h02, S_CHK_SET = 6'h04,
    S_CHK_TEST = 6'h08, S_WRITE = 6'h10, S_SEND = 6'h20
  } main_state_e;

  typedef enum logic [1:0] {TX_IDLE = 2'h1, TX_RUN = 2'h2} tx_state_e;
endpackage

/* File: logic/modbus_multi_write.sv */
/*
  Slave-side handler for multiple-coil and multiple-register write queries,
  with normal and exception replies.
  Assumes a framing layer that delivers received bytes with rx_valid and marks
  the end of a frame with rx_end, and a coil/register map that judges the
  presented item combinationally through item_code.
*/
// How it works
// - Coil query fields: header, bytecount, data, CRC.
// - Coil write success echoes eight-byte header reply.
// - First coil written is start field plus one.
// - Register query: header, bytecount, high-low pairs, CRC.
// - Register write success echoes eight-byte header reply.
// - First register written is start field plus one.
// - Register words high byte first, ascending order.
// - Two CRC bytes close every frame.
// - Broadcast writes are done but never answered.
// - Every addressed query gets a matching reply; the code drops a query with a bad CRC without any reply.
// - Failed or erroneous query gets exception reply; a query with a bad CRC is dropped with none.
// - Exception: address, function plus 80h, code, CRC.
// - Exception code names the specific error.
// - Codes 01h 02h 03h 21h 22h by cause.
`timescale 1ns/100ps
module modbus_multi_write (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] own_addr,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_end,
  input wire logic [7:0] item_code,
  input wire logic tx_ready,
  output logic [15:0] item_addr,
  output logic [15:0] item_data,
  output logic item_coil,
  output logic item_wr,
  output logic [7:0] tx_data,
  output logic tx_valid,
  output logic busy
);
  logic rst_meta_n_reg;
  logic rst_sync_n_reg;
  mb_pkg::main_state_e state_reg, state_next;
  logic [7:0] pos_reg, pos_next;
  logic [7:0] addr_reg, addr_next;
  logic [7:0] fn_reg, fn_next;
  logic [15:0] start_reg, start_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [7:0] bc_reg, bc_next;
  logic [7:0] buf_reg [mb_pkg::BUF_BYTES];
  logic [7:0] buf_next [mb_pkg::BUF_BYTES];
  logic [7:0] idx_reg, idx_next;
  logic exc_reg, exc_next;
  logic [7:0] code_reg, code_next;
  logic [15:0] item_addr_reg, item_addr_next;
  logic [15:0] item_data_reg, item_data_next;
  logic item_coil_reg, item_coil_next;
  logic item_wr_reg, item_wr_next;
  logic busy_reg, busy_next;
  logic tx_go_reg, tx_go_next;
  logic rx_take;
  logic [15:0] rx_crc;
  logic crc_ok;
  logic mine;
  logic fn_ok;
  logic fmt_bad;
  logic [15:0] coil_bytes;
  logic [8:0] frame_len;
  logic is_last;
  logic [7:0] coil_byte;
  logic [15:0] item_addr_calc;
  logic [15:0] item_data_calc;
  logic [3:0] tx_idx;
  logic tx_done;
  logic [7:0] rsp_byte;
  logic [3:0] rsp_len;

  // ---------------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n_reg <= 1'b0;
      rst_sync_n_reg <= 1'b0;
    end else begin
      rst_meta_n_reg <= 1'b1;
      rst_sync_n_reg <= rst_meta_n_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // Query capture
  // ---------------------------------------------------------------------------
  // Bytes arriving while a query is being served are dropped; the master
  // waits for the reply before the next query, so nothing legal is lost.
  assign rx_take = (state_reg == mb_pkg::S_IDLE) && rx_valid;

  always_comb begin
    pos_next = pos_reg;
    addr_next = addr_reg;
    fn_next = fn_reg;
    start_next = start_reg;
    cnt_next = cnt_reg;
    bc_next = bc_reg;
    if (state_reg == mb_pkg::S_EVAL) begin
      pos_next = '0;
    end else if (rx_take) begin
      if (pos_reg != mb_pkg::POS_MAX) begin
        pos_next = pos_reg + 8'h01;
      end
      case (pos_reg)
        mb_pkg::POS_ADDR: addr_next = rx_data;
        mb_pkg::POS_FN: fn_next = rx_data;
        mb_pkg::POS_ST_HI: start_next = {rx_data, start_reg[7:0]};
        mb_pkg::POS_ST_LO: start_next = {start_reg[15:8], rx_data};
        mb_pkg::POS_CNT_HI: cnt_next = {rx_data, cnt_reg[7:0]};
        mb_pkg::POS_CNT_LO: cnt_next = {cnt_reg[15:8], rx_data};
        mb_pkg::POS_BC: bc_next = rx_data;
        default: ;
      endcase
    end
  end

  // Data bytes beyond the buffer are never needed: such a query fails the
  // format check. The trailing CRC bytes land here too and are ignored.
  for (genvar g = 0; g < mb_pkg::BUF_BYTES; g++) begin : g_buf
    assign buf_next[g] = (rx_take && pos_reg == mb_pkg::HDR_LEN + 8'(g)) ? rx_data : buf_reg[g];
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      pos_reg <= '0;
      addr_reg <= '0;
      fn_reg <= '0;
      start_reg <= '0;
      cnt_reg <= '0;
      bc_reg <= '0;
      for (int i = 0; i < mb_pkg::BUF_BYTES; i++) begin
        buf_reg[i] <= '0;
      end
    end else begin
      pos_reg <= pos_next;
      addr_reg <= addr_next;
      fn_reg <= fn_next;
      start_reg <= start_next;
      cnt_reg <= cnt_next;
      bc_reg <= bc_next;
      buf_reg <= buf_next;
    end
  end

  crc16 u_rx_crc (
    .clk_sys(clk_sys),
    .rst_n(rst_sync_n_reg),
    .clear(state_reg == mb_pkg::S_EVAL),
    .en(rx_take),
    .data(rx_data),
    .crc(rx_crc)
  );

  // ---------------------------------------------------------------------------
  // Query checks
  // ---------------------------------------------------------------------------
  assign crc_ok = (rx_crc == mb_pkg::CRC_GOOD) && (pos_reg >= mb_pkg::MIN_LEN);
  assign mine = (addr_reg == own_addr) || (addr_reg == mb_pkg::ADDR_BCAST);
  assign fn_ok = (fn_reg == mb_pkg::FN_COILS) || (fn_reg == mb_pkg::FN_REGS);
  assign coil_bytes = (cnt_reg + mb_pkg::COIL_ROUND) >> mb_pkg::COIL_SHIFT;
  assign frame_len = {1'b0, bc_reg} + {1'b0, mb_pkg::HDR_LEN} + {1'b0, mb_pkg::CRC_LEN};

  always_comb begin
    fmt_bad = ({1'b0, pos_reg} != frame_len) || (bc_reg > mb_pkg::BUF_LEN) || (cnt_reg == '0);
    if (fn_reg == mb_pkg::FN_COILS) begin
      // An odd byte count is refused because the master must pad it.
      fmt_bad = fmt_bad || bc_reg[0] || (cnt_reg > mb_pkg::MAX_COILS) || ({8'h00, bc_reg} < coil_bytes);
    end else begin
      fmt_bad = fmt_bad || (cnt_reg > mb_pkg::MAX_REGS) || ({8'h00, bc_reg} != (cnt_reg << 1));
    end
  end

  // ---------------------------------------------------------------------------
  // Item generation
  // ---------------------------------------------------------------------------
  assign is_last = ({8'h00, idx_reg} == cnt_reg - mb_pkg::ADDR_STEP);
  assign coil_byte = buf_reg[idx_reg[6:3]];
  assign item_addr_calc = start_reg + mb_pkg::ADDR_STEP + {8'h00, idx_reg};

  always_comb begin
    if (fn_reg == mb_pkg::FN_COILS) begin
      item_data_calc = {15'h0000, coil_byte[idx_reg[2:0]]};
    end else begin
      item_data_calc = {buf_reg[{idx_reg[2:0], 1'b0}], buf_reg[{idx_reg[2:0], 1'b1}]};
    end
  end

  // ---------------------------------------------------------------------------
  // Control
  // ---------------------------------------------------------------------------
  // All items are checked before any is written, so a refused query never
  // leaves the map half updated. This costs two cycles per item.
  always_comb begin
    logic reply;
    reply = 1'b0;
    state_next = state_reg;
    idx_next = idx_reg;
    exc_next = exc_reg;
    code_next = code_reg;
    item_addr_next = item_addr_reg;
    item_data_next = item_data_reg;
    item_coil_next = item_coil_reg;
    item_wr_next = 1'b0;
    tx_go_next = 1'b0;
    case (state_reg)
      mb_pkg::S_IDLE: begin
        if (rx_end) begin
          state_next = mb_pkg::S_EVAL;
        end
      end
      mb_pkg::S_EVAL: begin
        exc_next = 1'b0;
        code_next = mb_pkg::EXC_NONE;
        idx_next = '0;
        if (!crc_ok || !mine) begin
          state_next = mb_pkg::S_IDLE;
        end else if (!fn_ok) begin
          exc_next = 1'b1;
          code_next = mb_pkg::EXC_FUNC;
          reply = 1'b1;
        end else if (fmt_bad) begin
          exc_next = 1'b1;
          code_next = mb_pkg::EXC_FORMAT;
          reply = 1'b1;
        end else begin
          state_next = mb_pkg::S_CHK_SET;
        end
      end
      mb_pkg::S_CHK_SET: begin
        item_addr_next = item_addr_calc;
        item_data_next = item_data_calc;
        item_coil_next = (fn_reg == mb_pkg::FN_COILS);
        state_next = mb_pkg::S_CHK_TEST;
      end
      mb_pkg::S_CHK_TEST: begin
        if (item_code != mb_pkg::EXC_NONE) begin
          exc_next = 1'b1;
          code_next = item_code;
          reply = 1'b1;
        end else if (is_last) begin
          idx_next = '0;
          state_next = mb_pkg::S_WRITE;
        end else begin
          idx_next = idx_reg + 8'h01;
          state_next = mb_pkg::S_CHK_SET;
        end
      end
      mb_pkg::S_WRITE: begin
        item_addr_next = item_addr_calc;
        item_data_next = item_data_calc;
        item_coil_next = (fn_reg == mb_pkg::FN_COILS);
        item_wr_next = 1'b1;
        if (is_last) begin
          reply = 1'b1;
        end else begin
          idx_next = idx_reg + 8'h01;
        end
      end
      mb_pkg::S_SEND: begin
        if (tx_done) begin
          state_next = mb_pkg::S_IDLE;
        end
      end
      default: state_next = mb_pkg::S_IDLE;
    endcase
    if (reply) begin
      if (addr_reg == mb_pkg::ADDR_BCAST) begin
        state_next = mb_pkg::S_IDLE;
      end else begin
        state_next = mb_pkg::S_SEND;
        tx_go_next = 1'b1;
      end
    end
  end

  assign busy_next = (state_next != mb_pkg::S_IDLE);

  always_ff @(posedge clk_sys or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      state_reg <= mb_pkg::S_IDLE;
      idx_reg <= '0;
      exc_reg <= 1'b0;
      code_reg <= mb_pkg::EXC_NONE;
      item_addr_reg <= '0;
      item_data_reg <= '0;
      item_coil_reg <= 1'b0;
      item_wr_reg <= 1'b0;
      busy_reg <= 1'b0;
      tx_go_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      exc_reg <= exc_next;
      code_reg <= code_next;
      item_addr_reg <= item_addr_next;
      item_data_reg <= item_data_next;
      item_coil_reg <= item_coil_next;
      item_wr_reg <= item_wr_next;
      busy_reg <= busy_next;
      tx_go_reg <= tx_go_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Reply
  // ---------------------------------------------------------------------------
  assign rsp_len = exc_reg ? mb_pkg::RSP_LEN_EXC : mb_pkg::RSP_LEN_OK;

  always_comb begin
    rsp_byte = 8'h00;
    if (tx_idx == mb_pkg::RI_ADDR) begin
      rsp_byte = addr_reg;
    end else if (tx_idx == mb_pkg::RI_FN) begin
      rsp_byte = exc_reg ? (fn_reg | mb_pkg::FN_EXC) : fn_reg;
    end else if (tx_idx == mb_pkg::RI_ST_HI) begin
      rsp_byte = exc_reg ? code_reg : start_reg[15:8];
    end else if (tx_idx == mb_pkg::RI_ST_LO) begin
      rsp_byte = start_reg[7:0];
    end else if (tx_idx == mb_pkg::RI_CNT_HI) begin
      rsp_byte = cnt_reg[15:8];
    end else if (tx_idx == mb_pkg::RI_CNT_LO) begin
      rsp_byte = cnt_reg[7:0];
    end
  end

  frame_tx u_tx (
    .clk_sys(clk_sys),
    .rst_n(rst_sync_n_reg),
    .start(tx_go_reg),
    .len(rsp_len),
    .byte_in(rsp_byte),
    .byte_idx(tx_idx),
    .tx_data(tx_data),
    .tx_valid(tx_valid),
    .tx_ready(tx_ready),
    .done(tx_done)
  );

  assign item_addr = item_addr_reg;
  assign item_data = item_data_reg;
  assign item_coil = item_coil_reg;
  assign item_wr = item_wr_reg;
  assign busy = busy_reg;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_sync_n_reg);

  sequence s_eval;
    state_reg == mb_pkg::S_EVAL;
  endsequence
  sequence s_good_query;
    s_eval ##0 crc_ok && mine;
  endsequence

  a_crc_discard: assert property (s_eval ##0 !crc_ok |=> state_reg == mb_pkg::S_IDLE && !tx_go_reg)
    else $error("Query with bad CRC was not dropped");
  a_unsup_func: assert property (s_good_query ##0 !fn_ok |=> exc_reg && code_reg == mb_pkg::EXC_FUNC)
    else $error("Unsupported function did not give code 01h");
  a_bcast_quiet: assert property (tx_go_reg |-> addr_reg != mb_pkg::ADDR_BCAST)
    else $error("Reply started for a broadcast query");
  a_first_addr: assert property (state_reg == mb_pkg::S_WRITE && idx_reg == '0
    |=> item_wr && item_addr == start_reg + mb_pkg::ADDR_STEP)
    else $error("First item address is not start plus one");
  a_reg_bytes: assert property (state_reg == mb_pkg::S_WRITE && idx_reg == '0 && fn_reg == mb_pkg::FN_REGS
    |=> !item_coil && item_data == {buf_reg[0], buf_reg[1]})
    else $error("First register word not high byte first");
  a_coil_lsb: assert property (state_reg == mb_pkg::S_WRITE && idx_reg == '0 && fn_reg == mb_pkg::FN_COILS
    |=> item_coil && item_data[0] == buf_reg[0][0])
    else $error("First coil not taken from bit 0");
  a_exc_no_wr: assert property (exc_reg |-> !item_wr)
    else $error("Item written while an exception is pending");
  a_map_code: assert property (state_reg == mb_pkg::S_CHK_TEST && item_code != mb_pkg::EXC_NONE
    |=> exc_reg && code_reg == $past(item_code) ##1 !item_wr[*2])
    else $error("Map refusal code not carried to the reply");
  // Checked on the wire: while the function byte stands, the fetch index already points one further.
  a_exc_fn_byte: assert property (state_reg == mb_pkg::S_SEND && exc_reg && tx_valid && tx_idx == mb_pkg::RI_ST_HI
    |-> tx_data == (fn_reg | mb_pkg::FN_EXC))
    else $error("Exception function byte is not query function plus 80h");
  a_reply_len: assert property (tx_go_reg |-> rsp_len == (exc_reg ? 4'h3 : 4'h6))
    else $error("Reply length does not match reply kind");
endmodule
